// ---- src/bsp_pkg.sv ----
// Package of constants, field layouts and carrier types for the bridge short protection block.
package bsp_pkg;

    localparam logic [7:0] FUSE_READBACK_OFFSET = 8'h05;
    localparam int FUSE_DEAD_MSB = 7;
    localparam int FUSE_DEAD_LSB = 6;
    localparam int FUSE_LEVEL_BIT = 5;
    localparam int FUSE_TRIM_MSB = 4;
    localparam int FUSE_TRIM_LSB = 0;

    localparam logic [3:0] DEAD_CODE0_CLKS = 4'h4;
    localparam logic [3:0] LEVEL_LOW_DEFAULT = 4'h6;
    localparam logic [3:0] LEVEL_HIGH_DEFAULT = 4'hc;
    localparam logic [3:0] LS_LEVEL_MIN = 4'h1;
    localparam logic [3:0] HS_LEVEL_MIN = 4'h2;

    localparam logic [1:0] FILTER_SEL_RESET = 2'h1;
    localparam logic [1:0] RETRY_RESET = 2'h3;
    localparam logic SHORT_DELAY_RESET = 1'b0;
    localparam logic ALL_PHASES_RESET = 1'b1;
    localparam logic [1:0] OT_SEL_RESET = 2'h0;
    localparam logic [1:0] OT_SEL_150 = 2'h0;
    localparam logic [1:0] OT_SEL_143 = 2'h1;
    localparam logic [1:0] OT_SEL_136 = 2'h2;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILT0_NS = 100;
    localparam int FILT1_NS = 1000;
    localparam int FILT2_NS = 2000;
    localparam int FILT3_NS = 3000;
    localparam int BLANK_SHORT_NS = 750;
    localparam int BLANK_LONG_NS = 1500;
    localparam int FILT0_CYC = (FILT0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT1_CYC = (FILT1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT2_CYC = (FILT2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT3_CYC = (FILT3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BLANK_LONG_CYC = (BLANK_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DECAY_CHOP_CYCLES = 256;
    localparam int LOAD_WAIT_CYC = 3;
    localparam int PHASES = 3;

    typedef struct packed {
        logic [3:0] dead_time;
        logic [4:0] osc_trim;
        logic [3:0] lowside_short_threshold;
        logic [3:0] highside_short_threshold;
        logic [1:0] short_spike_filter_sel;
        logic [1:0] retry_limit;
        logic short_delay_long;
        logic lowside_short_off;
        logic highside_short_off;
        logic shutdown_all_phases;
        logic [1:0] ot_select;
        logic short_direct;
    } bsp_config_type;

    typedef struct packed {
        logic [2:0] hs_short_flag;
        logic [2:0] ls_short_flag;
        logic overtemp_flag;
        logic prewarn_flag;
    } bsp_status_type;

endpackage : bsp_pkg

// ---- src/bsp_short_protect.sv ----
// Fuse defaults, overtemperature latch and per-phase short protection of a gate driver.
`timescale 1ns/1ps
`default_nettype none

module bsp_short_protect (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] fuse_cells,
    input wire logic fuse_prog_req,
    input wire logic [7:0] fuse_prog_data,
    input wire logic cfg_write,
    input wire bsp_pkg::bsp_config_type cfg_data,
    input wire logic driver_enable_pin,
    input wire logic temp_prewarn_raw,
    input wire logic temp_136_raw,
    input wire logic temp_143_raw,
    input wire logic temp_150_raw,
    input wire logic [2:0] hs_cmp_raw,
    input wire logic [2:0] ls_cmp_raw,
    input wire logic [2:0] hs_gate,
    input wire logic [2:0] ls_gate,
    input wire logic chopper_cycle,
    output var logic [7:0] fuse_readback_byte,
    output var logic [7:0] fuse_burn_mask,
    output var bsp_pkg::bsp_config_type cfg_active,
    output var bsp_pkg::bsp_status_type driver_status_flags,
    output var logic [2:0] bridge_enable,
    output var logic fault_out
);
    import bsp_pkg::*;

    function automatic logic [3:0] dead_from_code(input logic [1:0] code);
        dead_from_code = (code == 2'h0) ? DEAD_CODE0_CLKS : {2'h0, code};
    endfunction : dead_from_code

    function automatic logic [3:0] clamp_level(input logic [3:0] lvl, input logic [3:0] lo);
        clamp_level = (lvl < lo) ? lo : lvl;
    endfunction : clamp_level

    function automatic logic [9:0] filter_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: filter_cycles = 10'(FILT0_CYC);
            2'h1: filter_cycles = 10'(FILT1_CYC);
            2'h2: filter_cycles = 10'(FILT2_CYC);
            default: filter_cycles = 10'(FILT3_CYC);
        endcase
    endfunction : filter_cycles

    // Synchronisers: only the second stage is read by any logic.
    logic [7:0] fuse_s1, fuse_s2;
    logic [2:0] hs_s1, hs_s2, ls_s1, ls_s2;
    logic [3:0] temp_s1, temp_s2;
    logic en_s1, en_s2;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            fuse_s1 <= 8'h00;
            fuse_s2 <= 8'h00;
            hs_s1 <= 3'h0;
            hs_s2 <= 3'h0;
            ls_s1 <= 3'h0;
            ls_s2 <= 3'h0;
            temp_s1 <= 4'h0;
            temp_s2 <= 4'h0;
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end
        else
        begin
            fuse_s1 <= fuse_cells;
            fuse_s2 <= fuse_s1;
            hs_s1 <= hs_cmp_raw;
            hs_s2 <= hs_s1;
            ls_s1 <= ls_cmp_raw;
            ls_s2 <= ls_s1;
            temp_s1 <= {temp_150_raw, temp_143_raw, temp_136_raw, temp_prewarn_raw};
            temp_s2 <= temp_s1;
            en_s1 <= driver_enable_pin;
            en_s2 <= en_s1;
        end
    end

    // Fuse access and configuration registers.
    logic [1:0] load_cnt, next_load_cnt;
    logic [7:0] next_fuse_readback_byte, next_fuse_burn_mask;
    bsp_config_type next_cfg_active;

    always_comb
    begin
        next_load_cnt = load_cnt;
        next_cfg_active = cfg_active;
        next_fuse_readback_byte = fuse_s2;
        next_fuse_burn_mask = 8'h00;
        if (fuse_prog_req)
        begin
            // Only bits still at zero are burned; nothing can clear a cell.
            next_fuse_burn_mask = fuse_prog_data & ~fuse_s2;
        end
        if (load_cnt != 2'(LOAD_WAIT_CYC))
        begin
            next_load_cnt = load_cnt + 2'h1;
            if (load_cnt == 2'(LOAD_WAIT_CYC - 1))
            begin
                // Waits for the fuse synchroniser to fill before taking defaults.
                next_cfg_active.dead_time = dead_from_code(fuse_s2[FUSE_DEAD_MSB:FUSE_DEAD_LSB]);
                next_cfg_active.lowside_short_threshold = fuse_s2[FUSE_LEVEL_BIT] ?
                    LEVEL_HIGH_DEFAULT : LEVEL_LOW_DEFAULT;
                next_cfg_active.highside_short_threshold = fuse_s2[FUSE_LEVEL_BIT] ?
                    LEVEL_HIGH_DEFAULT : LEVEL_LOW_DEFAULT;
                next_cfg_active.osc_trim = fuse_s2[FUSE_TRIM_MSB:FUSE_TRIM_LSB];
            end
        end
        else if (cfg_write)
        begin
            next_cfg_active = cfg_data;
            next_cfg_active.lowside_short_threshold =
                clamp_level(cfg_data.lowside_short_threshold, LS_LEVEL_MIN);
            next_cfg_active.highside_short_threshold =
                clamp_level(cfg_data.highside_short_threshold, HS_LEVEL_MIN);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            load_cnt <= 2'h0;
            fuse_readback_byte <= 8'h00;
            fuse_burn_mask <= 8'h00;
            cfg_active <= '0;
            cfg_active.lowside_short_threshold <= LEVEL_LOW_DEFAULT;
            cfg_active.highside_short_threshold <= LEVEL_LOW_DEFAULT;
            cfg_active.dead_time <= DEAD_CODE0_CLKS;
            cfg_active.short_spike_filter_sel <= FILTER_SEL_RESET;
            cfg_active.retry_limit <= RETRY_RESET;
            cfg_active.short_delay_long <= SHORT_DELAY_RESET;
            cfg_active.shutdown_all_phases <= ALL_PHASES_RESET;
            cfg_active.ot_select <= OT_SEL_RESET;
        end
        else
        begin
            load_cnt <= next_load_cnt;
            fuse_readback_byte <= next_fuse_readback_byte;
            fuse_burn_mask <= next_fuse_burn_mask;
            cfg_active <= next_cfg_active;
        end
    end

    // Protection state: temperature latch and per-phase short detection and retry.
    logic [8:0] blank_cnt [PHASES];
    logic [8:0] next_blank_cnt [PHASES];
    logic [9:0] hs_filt [PHASES];
    logic [9:0] next_hs_filt [PHASES];
    logic [9:0] ls_filt [PHASES];
    logic [9:0] next_ls_filt [PHASES];
    logic [1:0] retry_cnt [PHASES];
    logic [1:0] next_retry_cnt [PHASES];
    logic [7:0] decay_cnt [PHASES];
    logic [7:0] next_decay_cnt [PHASES];
    logic [2:0] gate_prev, retry_hold, next_retry_hold, phase_dead, next_phase_dead;
    logic all_dead, next_all_dead, next_fault_out;
    logic [2:0] next_bridge_enable;
    bsp_status_type next_status;

    always_comb
    begin
        logic [8:0] blank_len;
        logic [9:0] filt_len;
        logic [2:0] hs_act, ls_act, hs_conf, ls_conf;
        logic level_hit;
        level_hit = 1'b0;
        blank_len = cfg_active.short_delay_long ? 9'(BLANK_LONG_CYC) : 9'(BLANK_SHORT_CYC);
        filt_len = filter_cycles(cfg_active.short_spike_filter_sel);
        hs_act = 3'h0;
        ls_act = 3'h0;
        hs_conf = 3'h0;
        ls_conf = 3'h0;
        next_status = driver_status_flags;
        next_retry_hold = retry_hold;
        next_phase_dead = phase_dead;
        next_all_dead = all_dead;
        case (cfg_active.ot_select)
            OT_SEL_150: level_hit = temp_s2[3];
            OT_SEL_143: level_hit = temp_s2[2];
            OT_SEL_136: level_hit = temp_s2[1];
            default: level_hit = temp_s2[0];
        endcase
        next_status.prewarn_flag = temp_s2[0];
        next_status.overtemp_flag = level_hit | (driver_status_flags.overtemp_flag & temp_s2[0]);
        for (int p = 0; p < PHASES; p++)
        begin
            next_blank_cnt[p] = blank_cnt[p];
            next_hs_filt[p] = 10'h000;
            next_ls_filt[p] = 10'h000;
            next_retry_cnt[p] = retry_cnt[p];
            next_decay_cnt[p] = decay_cnt[p];
            if ((hs_gate[p] ^ ls_gate[p]) != gate_prev[p])
            begin
                next_blank_cnt[p] = 9'h001;
            end
            else if (blank_cnt[p] != 9'h000 && blank_cnt[p] < blank_len)
            begin
                next_blank_cnt[p] = blank_cnt[p] + 9'h001;
            end
            // A shorter delay chosen mid-count counts as expired rather than wrapping round.
            if (blank_cnt[p] >= blank_len || blank_cnt[p] == 9'h000)
            begin
                // A phase held off is not driven, so its filter must start afresh on release.
                hs_act[p] = hs_gate[p] & hs_s2[p] & bridge_enable[p] &
                    ~cfg_active.highside_short_off;
                ls_act[p] = ls_gate[p] & ls_s2[p] & bridge_enable[p] &
                    ~cfg_active.lowside_short_off;
            end
            if (hs_act[p])
            begin
                next_hs_filt[p] = (hs_filt[p] == filt_len) ? hs_filt[p] : hs_filt[p] + 10'h001;
                hs_conf[p] = (hs_filt[p] == filt_len - 10'h001);
            end
            if (ls_act[p])
            begin
                next_ls_filt[p] = (ls_filt[p] == filt_len) ? ls_filt[p] : ls_filt[p] + 10'h001;
                ls_conf[p] = (ls_filt[p] == filt_len - 10'h001);
            end
            if (chopper_cycle)
            begin
                next_retry_hold[p] = 1'b0;
                if (cfg_active.retry_limit != 2'h0 && !phase_dead[p])
                begin
                    next_decay_cnt[p] = decay_cnt[p] + 8'h01;
                    if (decay_cnt[p] == 8'(DECAY_CHOP_CYCLES - 1) && retry_cnt[p] != 2'h0)
                    begin
                        next_retry_cnt[p] = retry_cnt[p] - 2'h1;
                    end
                end
            end
            if (hs_conf[p] || ls_conf[p])
            begin
                if (retry_cnt[p] >= cfg_active.retry_limit)
                begin
                    next_phase_dead[p] = 1'b1;
                    next_all_dead = all_dead | cfg_active.shutdown_all_phases;
                    next_status.hs_short_flag[p] = driver_status_flags.hs_short_flag[p] | hs_conf[p];
                    next_status.ls_short_flag[p] = driver_status_flags.ls_short_flag[p] | ls_conf[p];
                end
                else
                begin
                    // An event outranks a decay step in the same cycle.
                    next_retry_cnt[p] = retry_cnt[p] + 2'h1;
                    next_retry_hold[p] = 1'b1;
                end
            end
        end
        if (!en_s2)
        begin
            // Apart from sys_rst, disabling the driver is the only way out of a short shutdown.
            next_phase_dead = 3'h0;
            next_all_dead = 1'b0;
            next_retry_hold = 3'h0;
            next_status.hs_short_flag = 3'h0;
            next_status.ls_short_flag = 3'h0;
            for (int p = 0; p < PHASES; p++)
            begin
                next_retry_cnt[p] = 2'h0;
                next_decay_cnt[p] = 8'h00;
            end
        end
        for (int p = 0; p < PHASES; p++)
        begin
            next_bridge_enable[p] = en_s2 & ~next_status.overtemp_flag & ~next_phase_dead[p] &
                ~next_retry_hold[p] & ~next_all_dead;
        end
        next_fault_out = (|next_status.hs_short_flag) | (|next_status.ls_short_flag) |
            next_status.overtemp_flag | (cfg_active.short_direct & (|(hs_act | ls_act)));
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            for (int p = 0; p < PHASES; p++)
            begin
                blank_cnt[p] <= 9'h000;
                hs_filt[p] <= 10'h000;
                ls_filt[p] <= 10'h000;
                retry_cnt[p] <= 2'h0;
                decay_cnt[p] <= 8'h00;
            end
            gate_prev <= 3'h0;
            retry_hold <= 3'h0;
            phase_dead <= 3'h0;
            all_dead <= 1'b0;
            driver_status_flags <= '0;
            bridge_enable <= 3'h0;
            fault_out <= 1'b0;
        end
        else
        begin
            blank_cnt <= next_blank_cnt;
            hs_filt <= next_hs_filt;
            ls_filt <= next_ls_filt;
            retry_cnt <= next_retry_cnt;
            decay_cnt <= next_decay_cnt;
            gate_prev <= hs_gate ^ ls_gate;
            retry_hold <= next_retry_hold;
            phase_dead <= next_phase_dead;
            all_dead <= next_all_dead;
            driver_status_flags <= next_status;
            bridge_enable <= next_bridge_enable;
            fault_out <= next_fault_out;
        end
    end

endmodule : bsp_short_protect

`default_nettype wire

// ---- tb/bsp_fuse_array.sv ----
// Behavioural fuse array that sits behind the fuse readback and burn ports.
`timescale 1ns/1ps
`default_nettype none
module bsp_fuse_array (
    input wire logic mclk,
    input wire logic factory_load,
    input wire logic [7:0] factory_bits,
    input wire logic [7:0] burn_mask,
    output logic [7:0] cells
);
    // Factory load stands for trimming at test, so it may set any pattern at all.
    initial cells = 8'h00;
    always @(posedge mclk)
    begin
        if (factory_load)
            cells <= factory_bits;
        else
            cells <= cells | burn_mask;
    end
endmodule : bsp_fuse_array
`default_nettype wire

// ---- tb/bsp_short_protect_properties.sv ----
// Concurrent checks on the ports of the bridge short protection block.
`timescale 1ns/1ps
`default_nettype none
module bsp_short_protect_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic fuse_prog_req,
    input wire logic [7:0] fuse_prog_data,
    input wire logic driver_enable_pin,
    input wire logic temp_prewarn_raw,
    input wire logic [2:0] hs_cmp_raw,
    input wire logic [2:0] hs_gate,
    input wire logic [2:0] ls_gate,
    input wire logic [7:0] fuse_burn_mask,
    input wire bsp_pkg::bsp_config_type cfg_active,
    input wire bsp_pkg::bsp_status_type driver_status_flags,
    input wire logic [2:0] bridge_enable,
    input wire logic fault_out
);
    import bsp_pkg::*;
    logic [5:0] gate_prev;
    logic [5:0] next_gate_prev;
    logic [8:0] calm;
    logic [8:0] next_calm;
    logic [2:0] dead;
    assign dead = driver_status_flags.hs_short_flag | driver_status_flags.ls_short_flag;
    // Cycles since any gate moved; blanking can only have run out once this is large.
    always_comb
    begin
        next_gate_prev = {hs_gate, ls_gate};
        next_calm = calm;
        if (sys_rst || next_gate_prev != gate_prev)
            next_calm = 9'h000;
        else if (calm != 9'h1ff)
            next_calm = calm + 9'h001;
    end
    always_ff @(posedge mclk)
    begin
        gate_prev <= next_gate_prev;
        calm <= next_calm;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    a_burn_only_asked: assert property (
        fuse_prog_req |=> (fuse_burn_mask & ~$past(fuse_prog_data)) == 8'h00)
        else $error("burn mask holds a bit that was not requested");
    a_burn_idle_zero: assert property (!fuse_prog_req |=> fuse_burn_mask == 8'h00)
        else $error("burn mask active without a request");
    a_ls_level_floor: assert property (cfg_active.lowside_short_threshold >= 4'h1)
        else $error("low side threshold below its floor");
    a_hs_level_floor: assert property (cfg_active.highside_short_threshold >= 4'h2)
        else $error("high side threshold below its floor");
    a_ot_bridge_off: assert property (
        driver_status_flags.overtemp_flag [*3] |-> bridge_enable == 3'h0)
        else $error("bridge enabled while overtemperature is latched");
    a_ot_held_warm: assert property (
        (temp_prewarn_raw && driver_enable_pin) [*4] ##0 driver_status_flags.overtemp_flag
        |=> driver_status_flags.overtemp_flag)
        else $error("overtemperature released above the prewarning level");
    a_dead_phase_off: assert property ((dead & bridge_enable) == 3'h0)
        else $error("flagged phase still enabled");
    a_all_phases_off: assert property (
        $rose(|dead) && cfg_active.shutdown_all_phases |-> bridge_enable == 3'h0)
        else $error("final short left phases running");
    a_direct_fault: assert property (
        (cfg_active.short_direct && !cfg_active.highside_short_off && calm > 9'h136
        && (hs_cmp_raw & hs_gate) != 3'h0) [*3] |-> ##[0:3] fault_out)
        else $error("direct short not seen at the fault output");
    a_filter_min_time: assert property (
        $rose(|driver_status_flags.hs_short_flag) |-> $past(|hs_cmp_raw, 20))
        else $error("short flagged before the filter time");
    a_restart_clears: assert property ((!driver_enable_pin) [*5] |-> dead == 3'h0)
        else $error("short flags kept while driver disabled");
endmodule : bsp_short_protect_properties
bind bsp_short_protect bsp_short_protect_properties u_props (.mclk, .sys_rst, .fuse_prog_req,
    .fuse_prog_data, .driver_enable_pin, .temp_prewarn_raw, .hs_cmp_raw, .hs_gate, .ls_gate,
    .fuse_burn_mask, .cfg_active, .driver_status_flags, .bridge_enable, .fault_out);
`default_nettype wire

// ---- tb/tb_bsp_short_protect.sv ----
// Self-checking testbench for the bridge short protection block.
`timescale 1ns/1ps
`default_nettype none
module tb_bsp_short_protect;
    import bsp_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic preq = 1'b0;
    logic cfg_write = 1'b0;
    logic drv_en = 1'b1;
    logic chop = 1'b0;
    logic fload = 1'b0;
    logic fault_out;
    logic [3:0] temps = 4'h0;
    logic [7:0] pdata = 8'h00;
    logic [7:0] fbits = 8'h00;
    logic [7:0] cells;
    logic [7:0] rdbk;
    logic [7:0] burn;
    logic [7:0] fb;
    logic [2:0] hs_cmp = 3'h0;
    logic [2:0] ls_cmp = 3'h0;
    logic [2:0] hs_gate = 3'h0;
    logic [2:0] ls_gate = 3'h0;
    logic [2:0] bridge;
    bsp_config_type cfg_data = '0;
    bsp_config_type cfg_active;
    bsp_config_type c;
    bsp_status_type flags;
    int fails = 0;
    int checked = 0;
    int sel_q[$];
    logic [31:0] exp_q[$];
    string name_q[$];
    always #2.5 mclk = ~mclk;
    bsp_short_protect DUT (.mclk(mclk), .sys_rst(sys_rst), .fuse_cells(cells),
        .fuse_prog_req(preq), .fuse_prog_data(pdata), .cfg_write(cfg_write),
        .cfg_data(cfg_data), .driver_enable_pin(drv_en), .temp_prewarn_raw(temps[0]),
        .temp_136_raw(temps[1]), .temp_143_raw(temps[2]), .temp_150_raw(temps[3]),
        .hs_cmp_raw(hs_cmp), .ls_cmp_raw(ls_cmp), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .chopper_cycle(chop), .fuse_readback_byte(rdbk), .fuse_burn_mask(burn),
        .cfg_active(cfg_active), .driver_status_flags(flags), .bridge_enable(bridge),
        .fault_out(fault_out));
    bsp_fuse_array u_fuse (.mclk(mclk), .factory_load(fload), .factory_bits(fbits),
        .burn_mask(burn), .cells(cells));
    function automatic logic [31:0] seen(input int sel);
        case (sel)
            0: return {24'h0, rdbk};
            1: return {24'h0, burn};
            2: return {4'h0, cfg_active};
            3: return {24'h0, flags};
            4: return {29'h0, bridge};
            default: return {31'h0, fault_out};
        endcase
    endfunction : seen
    function automatic bsp_config_type dflt(input logic [7:0] b);
        bsp_config_type d;
        d = '0;
        d.dead_time = (b[7:6] == 2'h0) ? 4'h4 : {2'h0, b[7:6]};
        d.lowside_short_threshold = b[5] ? 4'hc : 4'h6;
        d.highside_short_threshold = d.lowside_short_threshold;
        d.osc_trim = b[4:0];
        d.short_spike_filter_sel = 2'h1;
        d.retry_limit = 2'h3;
        d.shutdown_all_phases = 1'b1;
        return d;
    endfunction : dflt
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Results are taken in the low half of the cycle, after the edge's updates settle.
    always @(negedge mclk)
        while (sel_q.size() > 0)
            check(name_q.pop_front(), seen(sel_q.pop_front()), exp_q.pop_front());
    task automatic note(input string what, input int sel, input logic [31:0] exp);
        name_q.push_back(what);
        sel_q.push_back(sel);
        exp_q.push_back(exp);
    endtask : note
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wait_for(input int sel, input logic [31:0] v, input int lim);
        for (int i = 0; i < lim && seen(sel) !== v; i++)
            tick(1);
    endtask : wait_for
    task automatic do_reset(input logic [7:0] b);
        sys_rst = 1'b1;
        fbits = b;
        fload = 1'b1;
        tick(1);
        fload = 1'b0;
        tick(15);
        sys_rst = 1'b0;
        tick(4);
    endtask : do_reset
    task automatic write_cfg(input bsp_config_type w);
        cfg_data = w;
        cfg_write = 1'b1;
        tick(1);
        cfg_write = 1'b0;
        tick(1);
    endtask : write_cfg
    task automatic restart();
        hs_cmp = 3'h0;
        ls_cmp = 3'h0;
        drv_en = 1'b0;
        tick(6);
        note("cleared", 3, 32'h0);
        drv_en = 1'b1;
        wait_for(4, 32'h7, 10);
        note("restarted", 4, 32'h7);
    endtask : restart
    task automatic end_of_test();
        $display("checks made %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        #200000;
        fails++;
        end_of_test();
    end
    initial
    begin
        int k;
        k = $urandom(32'he43eed0b);
        for (k = 0; k < 4; k++)
        begin
            fb = {k[1:0], k[0], 5'($urandom)};
            do_reset(fb);
            note("defaults", 2, {4'h0, dflt(fb)});
            note("readback", 0, {24'h0, fb});
        end
        $display("fuse default test done");
        pdata = 8'($urandom);
        preq = 1'b1;
        tick(1);
        preq = 1'b0;
        note("burn", 1, {24'h0, pdata & ~fb});
        tick(5);
        note("burnt", 0, {24'h0, pdata | fb});
        $display("fuse burn test done");
        for (k = 0; k < 3; k++)
        begin
            c = 28'($urandom);
            c.lowside_short_threshold = (k == 2) ? 4'hf : 4'(k);
            c.highside_short_threshold = c.lowside_short_threshold;
            write_cfg(c);
            if (k < 2) c.highside_short_threshold = 4'h2;
            if (k < 1) c.lowside_short_threshold = 4'h1;
            note("clamp", 2, {4'h0, c});
        end
        $display("threshold test done");
        c = dflt(fb);
        c.short_spike_filter_sel = 2'h0;
        c.retry_limit = 2'h1;
        c.shutdown_all_phases = 1'b0;
        c.highside_short_off = 1'b1;
        write_cfg(c);
        hs_gate = 3'h1;
        hs_cmp = 3'h1;
        tick(400);
        note("hs ignored", 4, 32'h7);
        c.highside_short_off = 1'b0;
        c.short_delay_long = 1'b1;
        write_cfg(c);
        hs_gate = 3'h0;
        tick(1);
        hs_gate = 3'h1;
        tick(290);
        note("blanked", 4, 32'h7);
        wait_for(4, 32'h6, 60);
        note("retry off", 4, 32'h6);
        note("retry flags", 3, 32'h0);
        chop = 1'b1;
        tick(1);
        chop = 1'b0;
        wait_for(4, 32'h7, 4);
        note("retry on", 4, 32'h7);
        wait_for(4, 32'h6, 700);
        note("hs flag", 3, 32'h20);
        note("one phase", 4, 32'h6);
        chop = 1'b1;
        tick(1);
        chop = 1'b0;
        tick(2);
        note("stays off", 4, 32'h6);
        restart();
        $display("retry test done");
        c.retry_limit = 2'h0;
        c.shutdown_all_phases = 1'b1;
        c.lowside_short_off = 1'b1;
        c.short_delay_long = 1'b0;
        write_cfg(c);
        ls_gate = 3'h2;
        ls_cmp = 3'h2;
        tick(400);
        note("ls ignored", 4, 32'h7);
        c.lowside_short_off = 1'b0;
        write_cfg(c);
        wait_for(4, 32'h0, 40);
        note("all off", 4, 32'h0);
        note("ls flag", 3, 32'h08);
        note("fault", 5, 32'h1);
        restart();
        $display("no retry test done");
        for (k = 0; k < 4; k++)
        begin
            c.ot_select = 2'(k);
            write_cfg(c);
            temps = {k == 0, k == 1, k == 2, 1'b1};
            wait_for(4, 32'h0, 10);
            note("ot off", 4, 32'h0);
            note("ot flags", 3, 32'h03);
            temps = 4'h1;
            tick(20);
            note("ot held", 4, 32'h0);
            temps = 4'h0;
            wait_for(4, 32'h7, 10);
            note("ot over", 4, 32'h7);
        end
        $display("overtemperature test done");
        c.short_direct = 1'b1;
        c.short_spike_filter_sel = 2'h3;
        write_cfg(c);
        hs_gate = 3'h4;
        tick(310);
        hs_cmp = 3'h4;
        wait_for(5, 32'h1, 8);
        note("direct", 5, 32'h1);
        tick(5);
        hs_cmp = 3'h0;
        tick(5);
        note("short pulse", 3, 32'h0);
        note("fault idle", 5, 32'h0);
        $display("direct fault test done");
        tick(2);
        end_of_test();
    end
endmodule : tb_bsp_short_protect
`default_nettype wire
